// file: shared/cdrld_pkg.sv
// constants, types and ratio decoding for the cdr lock supervisor
// assumes a single 40 MHz clock; the reference arrives as a one-cycle tick
package cdrld_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int RUN_TOL_NS    = 30000;
   // longest run of identical bits the loop must ride through, rounded down
   localparam int RUN_CYC       = RUN_TOL_NS / CLK_PERIOD_NS;
   localparam int GAP_W         = 11;
   localparam logic [GAP_W-1:0] RUN_LIMIT = GAP_W'(RUN_CYC);

   // nominal bit period of the recovered clock in system cycles
   localparam int PH_W = 3;
   localparam logic [PH_W-1:0] PH_LAST   = 3'h7;
   localparam logic [PH_W-1:0] PH_CENTER = 3'h4;
   localparam logic [PH_W-1:0] PH_EDGE   = 3'h1;
   localparam logic [PH_W-1:0] PH_ZERO   = 3'h0;

   // frequency check window, in reference ticks, and the ppm divisor
   localparam int CNT_W = 16;
   // 250 ticks is the shortest window whose tolerance still spans two counts at
   // ratio 8; a longer one would make every reacquisition slower
   localparam logic [CNT_W-1:0] WIN_REF = 16'h00fa;
   localparam logic [CNT_W-1:0] PPM_DIV = 16'h03e8;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   // ratio select encodings and recovered-to-reference ratios
   localparam logic [1:0] SEL_R8  = 2'h0;
   localparam logic [1:0] SEL_R10 = 2'h1;
   localparam logic [1:0] SEL_R16 = 2'h2;
   localparam logic [7:0] RATIO_8  = 8'h08;
   localparam logic [7:0] RATIO_10 = 8'h0a;
   localparam logic [7:0] RATIO_16 = 8'h10;
   localparam logic [7:0] RATIO_20 = 8'h14;

   // supervisor states, gray along hold -> acquire -> lock
   typedef enum logic [1:0] {
      ST_HOLD = 2'h0,
      ST_ACQ  = 2'h1,
      ST_LOCK = 2'h3
   } cdrld_state_t;

   typedef struct packed {
      logic lock;
      logic ref_mode;
   } cdrld_status_t;

   function automatic logic [7:0] cdrld_ratio(input logic [1:0] sel);
      case (sel)
         SEL_R8:  cdrld_ratio = RATIO_8;
         SEL_R10: cdrld_ratio = RATIO_10;
         SEL_R16: cdrld_ratio = RATIO_16;
         default: cdrld_ratio = RATIO_20;
      endcase
   endfunction

   // recovered ticks expected in one window
   function automatic logic [CNT_W-1:0] cdrld_expect(input logic [1:0] sel);
      cdrld_expect = CNT_W'({8'h00, cdrld_ratio(sel)} * WIN_REF);
   endfunction

endpackage

// file: rtl/cdrld_top.sv
// lock supervision, retiming and reference fallback of a serial data recovery loop
// assumes ser_din and ref_tick are synchronous to clk; ratio selects are static

module cdrld_top
   import cdrld_pkg::*;
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // line side and reference
   input  wire logic          ser_din,
   input  wire logic          ref_tick,
   // ratio selection
   input  wire logic          ratio_select_hi,
   input  wire logic          ratio_select_lo,
   // retimed stream and status
   output logic               rdata_q,
   output logic               rclk_q,
   output cdrld_status_t      status_q
);

   cdrld_state_t     state_q,   state_d;
   logic [PH_W-1:0]  phase_q,   phase_d;
   logic             prev_q,    prev_d;
   logic [GAP_W-1:0] gap_q,     gap_d;
   logic [CNT_W-1:0] refcnt_q,  refcnt_d;
   logic [CNT_W-1:0] rcnt_q,    rcnt_d;
   logic             rdata_d;
   logic             rclk_d;
   cdrld_status_t    status_d;

   logic             edge_w;
   logic             hold_w;
   logic             los_w;
   logic             win_end_w;
   logic             in_tol_w;
   logic [1:0]       sel_w;
   logic [CNT_W-1:0] expect_w;
   logic [CNT_W-1:0] tol_w;
   logic [CNT_W-1:0] diff_w;

   assign sel_w    = {ratio_select_hi, ratio_select_lo};
   assign expect_w = cdrld_expect(sel_w);
   assign tol_w    = expect_w / PPM_DIV;
   assign edge_w   = ser_din != prev_q;
   assign hold_w   = state_q == ST_HOLD;
   // a gap only counts as loss of signal once it outlasts the tolerated run
   assign los_w    = gap_q >= RUN_LIMIT;
   assign win_end_w = ref_tick && (refcnt_q == WIN_REF - CNT_ONE);
   assign diff_w   = (rcnt_q > expect_w) ? rcnt_q - expect_w : expect_w - rcnt_q;
   assign in_tol_w = diff_w <= tol_w;

   // recovered clock and retiming
   always_comb
   begin
      prev_d  = ser_din;
      // the gap saturates so a dead line can never wrap back into range
      gap_d   = edge_w ? GAP_W'(0) : (los_w ? gap_q : gap_q + GAP_W'(1));
      // in hold the phase free-runs at the nominal rate and ignores the line
      if (edge_w && !hold_w)
      begin
         phase_d = PH_EDGE;
      end
      else
      begin
         phase_d = (phase_q == PH_LAST) ? PH_ZERO : phase_q + PH_EDGE;
      end
      // both outputs are registered, so rdata_q takes its new bit in the cycle that rclk_q rises
      rclk_d  = phase_q == PH_CENTER;
      rdata_d = (phase_q == PH_CENTER) ? ser_din : rdata_q;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         phase_q <= PH_ZERO;
         prev_q  <= 1'b0;
         gap_q   <= '0;
         rclk_q  <= 1'b0;
         rdata_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         prev_q  <= prev_d;
         gap_q   <= gap_d;
         rclk_q  <= rclk_d;
         rdata_q <= rdata_d;
      end
   end

   // frequency check and supervisor
   always_comb
   begin
      // the window is counted in reference ticks, so its length follows the reference
      refcnt_d = ref_tick ? (win_end_w ? CNT_ZERO : refcnt_q + CNT_ONE) : refcnt_q;
      if (win_end_w)
      begin
         rcnt_d = CNT_ZERO;
      end
      else
      begin
         rcnt_d = rclk_d ? rcnt_q + CNT_ONE : rcnt_q;
      end
      state_d = state_q;
      case (state_q)
         ST_HOLD:
         begin
            // one window on the reference, then try the data again
            if (win_end_w)
            begin
               state_d = ST_ACQ;
            end
         end
         ST_ACQ:
         begin
            // losing the line while polling goes straight back to the reference
            if (los_w)
            begin
               state_d = ST_HOLD;
            end
            else if (win_end_w)
            begin
               state_d = in_tol_w ? ST_LOCK : ST_HOLD;
            end
         end
         ST_LOCK:
         begin
            // one failing window is enough; there is no hysteresis count
            if (los_w || (win_end_w && !in_tol_w))
            begin
               state_d = ST_HOLD;
            end
         end
         default: state_d = ST_HOLD;
      endcase
      status_d.lock     = state_d == ST_LOCK;
      status_d.ref_mode = state_d == ST_HOLD;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q  <= ST_HOLD;
         refcnt_q <= CNT_ZERO;
         rcnt_q   <= CNT_ZERO;
         status_q <= '{lock: 1'b0, ref_mode: 1'b1};
      end
      else
      begin
         state_q  <= state_d;
         refcnt_q <= refcnt_d;
         rcnt_q   <= rcnt_d;
         status_q <= status_d;
      end
   end

   // checks
   a_center_sample: assert property (@(posedge clk) disable iff (sys_rst)
      (edge_w && !hold_w) ##1 (!edge_w) [*4] |=> rclk_q)
      else $error("sample not at bit centre");
   a_fail_unlock: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == ST_LOCK && win_end_w && !in_tol_w) |=> (!status_q.lock && status_q.ref_mode))
      else $error("frequency failure did not drop lock");
   a_gap_to_ref: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q != ST_HOLD && los_w) |=> (state_q == ST_HOLD && status_q.ref_mode))
      else $error("lost signal did not fall back to reference");
   a_hold_freerun: assert property (@(posedge clk) disable iff (sys_rst)
      (hold_w && phase_q == PH_LAST) |=> (phase_q == PH_ZERO))
      else $error("phase not free-running in hold");
   a_hold_polls: assert property (@(posedge clk) disable iff (sys_rst)
      (hold_w && win_end_w) |=> (state_q == ST_ACQ))
      else $error("no reacquisition attempt after hold window");
   a_pass_locks: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == ST_ACQ && win_end_w && in_tol_w && !los_w) |=> status_q.lock)
      else $error("lock not declared on passing window");
   a_run_ridden: assert property (@(posedge clk) disable iff (sys_rst)
      (state_q == ST_LOCK && gap_q < RUN_LIMIT - GAP_W'(1) && !win_end_w) |=> status_q.lock)
      else $error("lock lost inside tolerated run");
   a_ratio_map: assert property (@(posedge clk) disable iff (sys_rst)
      (sel_w == SEL_R10) |-> (expect_w == CNT_W'(8'h0a) * WIN_REF))
      else $error("ratio select decoded wrongly");
   a_lock_mirror: assert property (@(posedge clk) disable iff (sys_rst)
      (!status_q.lock && !(state_q == ST_ACQ && win_end_w && in_tol_w && !los_w))
      |=> !status_q.lock)
      else $error("lock output returned without lock");
   // retiming: one-cycle strobe, data taken at the centre phase and then held
   a_single_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      rclk_q |=> !rclk_q)
      else $error("recovered strobe wider than one cycle");
   a_centre_take: assert property (@(posedge clk) disable iff (sys_rst)
      (phase_q == PH_CENTER) |=> (rclk_q && rdata_q == $past(ser_din)))
      else $error("data not taken at bit centre");
   a_data_held: assert property (@(posedge clk) disable iff (sys_rst)
      (phase_q != PH_CENTER) |=> $stable(rdata_q))
      else $error("retimed data changed off the strobe");
   a_poll_realign: assert property (@(posedge clk) disable iff (sys_rst)
      (edge_w && !hold_w) |=> (phase_q == PH_EDGE))
      else $error("data edge ignored while polling");
   a_hold_ignores: assert property (@(posedge clk) disable iff (sys_rst)
      (hold_w && edge_w && phase_q != PH_LAST) |=> (phase_q == $past(phase_q) + PH_EDGE))
      else $error("data edge moved phase in hold");
   // supervisor: hold never jumps straight to lock, a dead line stays dead
   a_hold_no_lock: assert property (@(posedge clk) disable iff (sys_rst)
      hold_w |=> !status_q.lock)
      else $error("lock declared straight from hold");
   a_gap_sticks: assert property (@(posedge clk) disable iff (sys_rst)
      (los_w && !edge_w) |=> los_w)
      else $error("loss of signal cleared without a transition");

endmodule

// file: verif/cdrld_line_model.sv
// line-side data source and free-running reference tick
// assumes the bench drives pat and quiet at the rising edge
module cdrld_line_model
(
   // clock
   input  wire logic       clk,
   // control from the bench
   input  wire logic [7:0] pat,
   input  wire logic       quiet,
   // line side
   output logic            ser_din,
   output logic            ref_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ph_q  = 3'h0;
   logic [2:0] idx_q = 3'h0;
   logic [5:0] rc_q  = 6'h00;
   logic       din_q = 1'b0;
   logic       tk_q  = 1'b0;
   assign ser_din  = din_q;
   assign ref_tick = tk_q;
   // reference runs at 64 cycles whatever the selects say, so a wrong select fails
   always @(posedge clk)
   begin
      ph_q <= ph_q + 3'h1;
      rc_q <= rc_q + 6'h01;
      tk_q <= (rc_q == 6'h3f);
      // quiet holds the line still: a long run of one level
      if (ph_q == 3'h7 && !quiet)
      begin
         idx_q <= idx_q + 3'h1;
         din_q <= pat[idx_q];
      end
   end
endmodule

// file: verif/cdr_lock_detect_refsel_tb.sv
// self-checking bench for the lock supervisor
// assumes one 40 MHz clock; a full lock takes two 16000-cycle windows
module cdr_lock_detect_refsel_tb
   import cdrld_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          clk = 1'b0;
   logic          sys_rst = 1'b1;
   logic          ratio_select_hi = 1'b0;
   logic          ratio_select_lo = 1'b0;
   logic [7:0]    pat = 8'h55;
   logic          quiet = 1'b0;
   logic          ser_din, ref_tick, rdata_q, rclk_q, tick_q;
   cdrld_status_t status_q;
   int            fail_count = 0;
   int            checked = 0;
   int            cyc = 0;
   // each row: line pattern, then the lock level it should leave
   logic [8:0]    rows [5] = '{{8'h0f, 1'b1}, {8'h00, 1'b1}, {8'he1, 1'b1}, {8'hff, 1'b1},
                               {8'h55, 1'b1}};

   always #12.5 clk = ~clk;

   cdrld_line_model line (.clk(clk), .pat(pat), .quiet(quiet), .ser_din(ser_din),
      .ref_tick(ref_tick));
   cdrld_top dut (.clk(clk), .sys_rst(sys_rst), .ser_din(ser_din), .ref_tick(ref_tick),
      .ratio_select_hi(ratio_select_hi), .ratio_select_lo(ratio_select_lo),
      .rdata_q(rdata_q), .rclk_q(rclk_q), .status_q(status_q));

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      tick_q <= ref_tick;
      cyc++;
      // five windows of 16000 cycles, one more than the four the test needs plus the hand-written cases
      if (cyc == 80000)
      begin
         fail_count++;
         finish_test();
      end
   end

   // sampled on the falling edge so outputs have settled
   always @(negedge clk)
      if (rclk_q === 1'b1 && status_q.lock === 1'b1)
         cmp_bit(rdata_q, ser_din, "retimed bit");

   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      cmp_bit(status_q.lock, 1'b0, "lock after reset");
      cmp_bit(status_q.ref_mode, 1'b1, "hold after reset");
      for (int i = 0; i < 20000 && status_q.ref_mode !== 1'b0; i++) @(negedge clk);
      cmp_bit(status_q.ref_mode, 1'b0, "polling data");
      cmp_bit(status_q.lock, 1'b0, "early lock");
      for (int i = 0; i < 20000 && status_q.lock !== 1'b1; i++) @(negedge clk);
      cmp_bit(status_q.lock, 1'b1, "lock");
      cmp_bit(tick_q, 1'b1, "lock off window end");
      foreach (rows[r])
      begin
         @(posedge clk);
         pat <= rows[r][8:1];
         repeat (64) @(posedge clk);
         @(negedge clk);
         cmp_bit(status_q.lock, rows[r][0], "lock with pattern");
      end
      // last row toggles every bit, so the strobe must come every 8 cycles
      for (int i = 0; i < 16 && rclk_q !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      cmp_bit(rclk_q, 1'b0, "strobe longer than a cycle");
      repeat (7) @(negedge clk);
      cmp_bit(rclk_q, 1'b1, "strobe off the bit period");
      // run just short of the loss-of-signal gap
      @(posedge clk);
      quiet <= 1'b1;
      repeat (1150) @(posedge clk);
      @(negedge clk);
      cmp_bit(status_q.lock, 1'b1, "lock through long run");
      // ratio 10 against a ratio 8 reference is far outside tolerance
      @(posedge clk);
      quiet <= 1'b0;
      ratio_select_lo <= 1'b1;
      @(negedge clk);
      for (int i = 0; i < 20000 && status_q.lock !== 1'b0; i++) @(negedge clk);
      cmp_bit(status_q.lock, 1'b0, "loss of lock");
      cmp_bit(status_q.ref_mode, 1'b1, "follow reference");
      cmp_bit(tick_q, 1'b1, "loss at window end");
      repeat (1000) @(negedge clk);
      cmp_bit(status_q.lock, 1'b0, "lock stays low");
      // the line dies while polling: loss of signal must return to the reference
      for (int i = 0; i < 20000 && status_q.ref_mode !== 1'b0; i++) @(negedge clk);
      cmp_bit(status_q.ref_mode, 1'b0, "polling after loss");
      @(posedge clk);
      quiet <= 1'b1;
      repeat (1250) @(negedge clk);
      cmp_bit(status_q.ref_mode, 1'b1, "reference on dead line");
      cmp_bit(status_q.lock, 1'b0, "lock on dead line");
      finish_test();
   end
endmodule
